// *** core/lpmr_latency_decode.sv ***
/*
  Decodes the stored latency code into read and write latency cycle counts.
  Assumes the code was already screened for reserved values.
*/
`timescale 1ns/1ps
`default_nettype none
`include "lpmr_map.svh"
module lpmr_latency_decode (
  input wire logic [3:0] code,
  output lpmr_pkg::lpmr_lat_t lat
);
  import lpmr_pkg::*;
  always_comb begin
    case (code)
      4'h2: lat = '{read_latency_cycles: 4'h4, write_latency_cycles: 3'h2};
      4'h3: lat = '{read_latency_cycles: 4'h5, write_latency_cycles: 3'h2};
      4'h4: lat = '{read_latency_cycles: 4'h6, write_latency_cycles: 3'h3};
      4'h5: lat = '{read_latency_cycles: 4'h7, write_latency_cycles: 3'h4};
      4'h6: lat = '{read_latency_cycles: 4'h8, write_latency_cycles: 3'h4};
      default: lat = '{read_latency_cycles: 4'h3, write_latency_cycles: 3'h1};
    endcase
  end
endmodule : lpmr_latency_decode
`default_nettype wire

// *** core/lpmr_mode_regs.sv ***
/*
  Mode registers for latency, drive strength, temperature status and maker id.
  Assumes commands arrive as one-cycle strobes synchronous to clock; the sensor
  code is synchronous too.
*/
`timescale 1ns/1ps
`default_nettype none
`include "lpmr_map.svh"
module lpmr_mode_regs (
  input wire logic clock,
  input wire logic rst,
  input wire lpmr_pkg::lpmr_cmd_t cmd,
  input wire logic [2:0] sensor_rate,
  output logic rd_valid,
  output logic [7:0] rd_data,
  output logic [3:0] read_latency_cycles,
  output logic [2:0] write_latency_cycles,
  output logic [3:0] output_drive_strength,
  output logic derate_timing,
  output logic temp_unsafe
);
  import lpmr_pkg::*;

  logic [3:0] lat_code_q, lat_code_d;
  logic [3:0] drv_q, drv_d;
  logic [2:0] rate_q, rate_d;
  logic tuf_q, tuf_d;
  logic rd_valid_q, rd_valid_d;
  logic [7:0] rd_data_q, rd_data_d;
  lpmr_state_t state_q, state_d;
  lpmr_lat_t lat_dec;
  lpmr_lat_t lat_q, lat_d;
  logic drtq_q, drtq_d, uns_q, uns_d;
  logic rate_changes, temp_read;

  lpmr_latency_decode u_lat (
    .code(lat_code_q),
    .lat(lat_dec)
  );

  assign rate_changes = (sensor_rate != rate_q);
  assign temp_read = cmd.rd && (cmd.addr == `LPMR_ADDR_TEMP);

  always_comb begin
    lat_code_d = lat_code_q;
    drv_d = drv_q;
    // reserved codes are dropped so the active setting stays legal
    if (cmd.wr && cmd.addr == `LPMR_ADDR_LATENCY &&
        cmd.wdata[3:0] >= `LPMR_LAT_MIN && cmd.wdata[3:0] <= `LPMR_LAT_MAX) begin
      lat_code_d = cmd.wdata[3:0];
    end
    if (cmd.wr && cmd.addr == `LPMR_ADDR_DRIVE) begin
      case (cmd.wdata[3:0])
        4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7: drv_d = cmd.wdata[3:0];
        default: drv_d = drv_q;
      endcase
    end
  end

  always_comb begin
    // sensor code reserved value 4 is never stored
    rate_d = (sensor_rate == `LPMR_RATE_RESERVED) ? rate_q : sensor_rate;
    tuf_d = tuf_q;
    if (temp_read) begin
      tuf_d = 1'b0;
    end
    // a change in the read cycle still wins, so it is never lost
    if (rate_d != rate_q) begin
      tuf_d = 1'b1;
    end
    drtq_d = (rate_q == `LPMR_RATE_DERATE);
    uns_d = (rate_q == `LPMR_RATE_LOW_LIMIT) || (rate_q == `LPMR_RATE_HIGH_LIMIT);
    lat_d = lat_dec;
  end

  always_comb begin
    state_d = LPMR_IDLE;
    rd_valid_d = 1'b0;
    rd_data_d = rd_data_q;
    case (state_q)
      LPMR_IDLE: begin
        if (cmd.rd) begin
          state_d = LPMR_READ_OUT;
          rd_valid_d = 1'b1;
          case (cmd.addr)
            `LPMR_ADDR_TEMP: rd_data_d = {tuf_q, 4'h0, rate_q};
            `LPMR_ADDR_IDENT: rd_data_d = `LPMR_MAKER_ID;
            // write-only and unmapped addresses read as zero
            default: rd_data_d = 8'h00;
          endcase
        end
      end
      LPMR_READ_OUT: begin
        state_d = LPMR_IDLE;
        if (cmd.rd) begin
          state_d = LPMR_READ_OUT;
          rd_valid_d = 1'b1;
          case (cmd.addr)
            `LPMR_ADDR_TEMP: rd_data_d = {tuf_q, 4'h0, rate_q};
            `LPMR_ADDR_IDENT: rd_data_d = `LPMR_MAKER_ID;
            default: rd_data_d = 8'h00;
          endcase
        end
      end
      default: state_d = LPMR_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      lat_code_q <= `LPMR_LAT_RESET;
      drv_q <= `LPMR_DRV_RESET;
      rate_q <= `LPMR_RATE_RESET;
      tuf_q <= 1'b0;
      rd_valid_q <= 1'b0;
      rd_data_q <= 8'h00;
      state_q <= LPMR_IDLE;
      lat_q <= '{read_latency_cycles: 4'h3, write_latency_cycles: 3'h1};
      drtq_q <= 1'b0;
      uns_q <= 1'b0;
    end else begin
      lat_code_q <= lat_code_d;
      drv_q <= drv_d;
      rate_q <= rate_d;
      tuf_q <= tuf_d;
      rd_valid_q <= rd_valid_d;
      rd_data_q <= rd_data_d;
      state_q <= state_d;
      lat_q <= lat_d;
      drtq_q <= drtq_d;
      uns_q <= uns_d;
    end
  end

  assign rd_valid = rd_valid_q;
  assign rd_data = rd_data_q;
  assign read_latency_cycles = lat_q.read_latency_cycles;
  assign write_latency_cycles = lat_q.write_latency_cycles;
  assign output_drive_strength = drv_q;
  assign derate_timing = drtq_q;
  assign temp_unsafe = uns_q;

  sequence s_rate_moves;
    !rst && sensor_rate != rate_q && sensor_rate != `LPMR_RATE_RESERVED;
  endsequence
  sequence s_temp_read;
    temp_read && !rate_changes;
  endsequence

  a_tuf_set: assert property (@(posedge clock) disable iff (rst)
    s_rate_moves |=> tuf_q) else $error("update flag not set on rate change");
  a_tuf_clear: assert property (@(posedge clock) disable iff (rst)
    s_temp_read |=> !tuf_q) else $error("update flag not cleared by read");
  a_tuf_reset: assert property (@(posedge clock)
    rst |=> !tuf_q) else $error("update flag not zero after reset");
  a_temp_data: assert property (@(posedge clock) disable iff (rst)
    temp_read |=> rd_valid && rd_data == {$past(tuf_q), 4'h0, $past(rate_q)})
    else $error("temperature read data wrong");
  a_hot_bit: assert property (@(posedge clock) disable iff (rst)
    temp_read && rate_q[`LPMR_RATE_HOT_BIT] |=> rd_data[2])
    else $error("hot bit missing");
  a_ident_data: assert property (@(posedge clock) disable iff (rst)
    cmd.rd && cmd.addr == `LPMR_ADDR_IDENT |=> rd_data == `LPMR_MAKER_ID)
    else $error("maker code wrong");
  a_lat_reserved: assert property (@(posedge clock) disable iff (rst)
    cmd.wr && cmd.addr == `LPMR_ADDR_LATENCY && cmd.wdata[3:0] > `LPMR_LAT_MAX
    |=> $stable(lat_code_q)) else $error("reserved latency accepted");
  a_drv_write: assert property (@(posedge clock) disable iff (rst)
    cmd.wr && cmd.addr == `LPMR_ADDR_DRIVE && cmd.wdata[3:0] == 4'h5
    |=> $stable(drv_q)) else $error("reserved drive code accepted");
  a_derate: assert property (@(posedge clock) disable iff (rst)
    rate_q == `LPMR_RATE_DERATE |=> derate_timing) else $error("derate not flagged");
  a_wo_read: assert property (@(posedge clock) disable iff (rst)
    cmd.rd && cmd.addr == `LPMR_ADDR_DRIVE |=> rd_data == 8'h00)
    else $error("write-only register readable");

  // read answer is a single pulse; data holds between reads
  a_rd_pulse: assert property (@(posedge clock) disable iff (rst)
    !cmd.rd |=> !rd_valid) else $error("read valid without read");

  a_rd_hold: assert property (@(posedge clock) disable iff (rst)
    !cmd.rd |=> $stable(rd_data)) else $error("read data moved without read");

  sequence s_lat_write;
    cmd.wr && cmd.addr == `LPMR_ADDR_LATENCY;
  endsequence

  a_lat_store: assert property (@(posedge clock) disable iff (rst)
    s_lat_write ##0 (cmd.wdata[3:0] >= 4'h1 && cmd.wdata[3:0] <= 4'h6)
    |=> lat_code_q == $past(cmd.wdata[3:0])) else $error("legal latency not stored");

  a_lat_zero: assert property (@(posedge clock) disable iff (rst)
    s_lat_write ##0 cmd.wdata[3:0] == 4'h0
    |=> $stable(lat_code_q)) else $error("latency code zero accepted");

  a_lat_decode: assert property (@(posedge clock) disable iff (rst)
    lat_code_q == 4'h6 |=> read_latency_cycles == 4'h8 && write_latency_cycles == 3'h4)
    else $error("latency code six decoded wrong");

  a_drv_accept: assert property (@(posedge clock) disable iff (rst)
    cmd.wr && cmd.addr == `LPMR_ADDR_DRIVE && cmd.wdata[3:0] == 4'h7
    |=> output_drive_strength == 4'h7) else $error("drive code seven not taken");

  a_drv_upper: assert property (@(posedge clock) disable iff (rst)
    cmd.wr && cmd.addr == `LPMR_ADDR_DRIVE && cmd.wdata[3:0] > 4'h7
    |=> $stable(drv_q)) else $error("upper drive code accepted");

  a_unsafe_high: assert property (@(posedge clock) disable iff (rst)
    rate_q == `LPMR_RATE_HIGH_LIMIT |=> temp_unsafe) else $error("high limit not flagged");

  a_nominal_rate: assert property (@(posedge clock) disable iff (rst)
    rate_q == 3'h3 |=> !temp_unsafe && !derate_timing) else $error("nominal rate flagged");

  a_rate_reserved: assert property (@(posedge clock) disable iff (rst)
    sensor_rate == `LPMR_RATE_RESERVED |=> $stable(rate_q))
    else $error("reserved rate code stored");

  a_rate_track: assert property (@(posedge clock) disable iff (rst)
    sensor_rate != `LPMR_RATE_RESERVED |=> rate_q == $past(sensor_rate))
    else $error("rate code does not follow sensor");

  a_no_derate: assert property (@(posedge clock) disable iff (rst)
    rate_q == 3'h5 |=> !derate_timing) else $error("derate flagged for code five");
endmodule : lpmr_mode_regs
`default_nettype wire

// *** include/lpmr_map.svh ***
/*
  Offsets, field positions, reset values and codes of the mode-register group.
  Assumes one 8-bit mode-register address space shared with other registers.
*/
// Function
// - latency field bits 3:0 write-only; codes 1-6 valid, code 1 default
// - drive field bits 3:0 write-only; codes 1-4,6,7 valid, code 2 default
// - temperature register holds read-only 3-bit refresh code; 0 low, 7 high limit
// - codes 5 and 6 mean 0.25x refresh; 6 also asks for derating
// - update flag bit 7 set when refresh code changed since last read
// - reading temperature register clears update flag
// - update flag is zero after power-up
// - refresh code bit 2 set means die above 85 degrees
// - identification register returns 8-bit maker code on bits 7:0, read-only
// - drive register at 03h, temperature 04h, identification 05h; other bits reserved
// - latency register at 02h, upper four bits reserved
`ifndef LPMR_MAP_SVH
`define LPMR_MAP_SVH
`define LPMR_ADDR_LATENCY 8'h02
`define LPMR_ADDR_DRIVE 8'h03
`define LPMR_ADDR_TEMP 8'h04
`define LPMR_ADDR_IDENT 8'h05
`define LPMR_LAT_RESET 4'h1
`define LPMR_LAT_MIN 4'h1
`define LPMR_LAT_MAX 4'h6
`define LPMR_DRV_RESET 4'h2
`define LPMR_TUF_BIT 7
`define LPMR_RATE_HOT_BIT 2
`define LPMR_RATE_RESET 3'h3
`define LPMR_RATE_LOW_LIMIT 3'h0
`define LPMR_RATE_HIGH_LIMIT 3'h7
`define LPMR_RATE_RESERVED 3'h4
`define LPMR_RATE_DERATE 3'h6
// arbitrary maker code of our own, not an assigned one
`define LPMR_MAKER_ID 8'h5a
`endif

// *** include/lpmr_pkg.sv ***
/*
  Types of the mode-register group.
  Assumes lpmr_map.svh for numeric constants.
*/
package lpmr_pkg;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lpmr_cmd_t;
  typedef struct packed {
    logic [3:0] read_latency_cycles;
    logic [2:0] write_latency_cycles;
  } lpmr_lat_t;
  typedef enum logic [1:0] {
    LPMR_IDLE,
    LPMR_READ_OUT
  } lpmr_state_t;
endpackage : lpmr_pkg

// *** verification/lpmr_host_model.sv ***
/*
  Controller model issuing mode-register commands.
  Assumes callers sit on a falling clock edge when calling op.
*/
`timescale 1ns/1ps
`default_nettype none
module lpmr_host_model (
  input wire logic clock,
  output lpmr_pkg::lpmr_cmd_t cmd,
  input wire logic derate_timing,
  input wire logic temp_unsafe,
  output logic stop_traffic,
  output logic [11:0] derate_add_ps
);
  import lpmr_pkg::*;
  initial cmd = '0;
  // halt array traffic, die out of range
  assign stop_traffic = temp_unsafe;
  // 1875 ps onto the row timings
  assign derate_add_ps = derate_timing ? 12'h753 : 12'h000;
  // held until the next call, so it repeats on every rising edge that the caller waits through
  task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    cmd <= '{wr: w, rd: r, addr: a, wdata: d};
    @(negedge clock);
  endtask : op
endmodule : lpmr_host_model
`default_nettype wire

// *** verification/lpmr_mode_regs_test.sv ***
/*
  Self-checking bench of the mode-register group.
  Assumes lpmr_host_model drives the command port.
*/
`timescale 1ns/1ps
`default_nettype none
`include "lpmr_map.svh"
module lpmr_mode_regs_test;
  import lpmr_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [2:0] sensor_rate = 3'h3;
  lpmr_cmd_t cmd;
  logic rd_valid, derate_timing, temp_unsafe, stop_traffic, flag;
  logic [7:0] rd_data;
  logic [3:0] rl, drv, drv_m;
  logic [2:0] wl, rate_m;
  logic [11:0] derate_add_ps;
  logic [7:0] lat_tab [1:6] = '{8'h31, 8'h42, 8'h52, 8'h63, 8'h74, 8'h84};
  int err_count = 0;
  int n_tests = 0;
  lpmr_mode_regs dut (.clock(clock), .rst(rst), .cmd(cmd), .sensor_rate(sensor_rate),
    .rd_valid(rd_valid), .rd_data(rd_data), .read_latency_cycles(rl),
    .write_latency_cycles(wl), .output_drive_strength(drv),
    .derate_timing(derate_timing), .temp_unsafe(temp_unsafe));
  lpmr_host_model host (.clock(clock), .cmd(cmd), .derate_timing(derate_timing),
    .temp_unsafe(temp_unsafe), .stop_traffic(stop_traffic), .derate_add_ps(derate_add_ps));
  initial begin
    forever #20 clock = ~clock;
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic idle(input int n);
    repeat (n) host.op(1'b0, 1'b0, 8'h00, 8'h00);
  endtask : idle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.op(1'b1, 1'b0, a, d);
    idle(1);
  endtask : wr
  // answer fixed at one cycle; leaves the read strobe up for back-to-back use
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    host.op(1'b0, 1'b1, a, 8'h00);
    chk("rd_valid", 8'h01, {7'h00, rd_valid});
    chk("rd_data", exp, rd_data);
  endtask : rd
  task automatic close_out;
    $display("checks %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out
  initial begin
    repeat (3000) @(posedge clock);
    err_count++;
    close_out();
  end
  initial begin
    repeat (6) @(negedge clock);
    rst <= 1'b0;
    chk("latency", 8'h31, {rl, 1'b0, wl});
    chk("drive", 8'h02, {4'h0, drv});
    rd(`LPMR_ADDR_TEMP, 8'h03);
    rd(`LPMR_ADDR_IDENT, `LPMR_MAKER_ID);
    rd(8'h02, 8'h00);
    rd(8'h03, 8'h00);
    rd(8'h06, 8'h00);
    idle(1);
    chk("rd_valid_low", 8'h00, {7'h00, rd_valid});
    wr(`LPMR_ADDR_TEMP, 8'h86);
    wr(`LPMR_ADDR_IDENT, 8'hff);
    rd(`LPMR_ADDR_TEMP, 8'h03);
    rd(`LPMR_ADDR_IDENT, `LPMR_MAKER_ID);
    for (int c = 1; c < 17; c++) begin
      wr(`LPMR_ADDR_LATENCY, {4'h0, c[3:0]});
      chk("latency", lat_tab[(c < 7) ? c : 6], {rl, 1'b0, wl});
    end
    drv_m = 4'h2;
    for (int c = 0; c < 16; c++) begin
      wr(`LPMR_ADDR_DRIVE, {4'h0, c[3:0]});
      if ((c >= 1 && c <= 4) || c == 6 || c == 7) drv_m = c[3:0];
      chk("drive", {4'h0, drv_m}, {4'h0, drv});
    end
    rate_m = 3'h3;
    for (int c = 0; c < 8; c++) begin
      flag = 1'b0;
      if (c != 4 && c[2:0] != rate_m) begin
        rate_m = c[2:0];
        flag = 1'b1;
      end
      sensor_rate <= c[2:0];
      idle(2);
      chk("derate", {7'h00, rate_m == 3'h6}, {7'h00, derate_timing});
      chk("unsafe", {7'h00, rate_m == 3'h0 || rate_m == 3'h7}, {7'h00, stop_traffic});
      chk("derate_add", (rate_m == 3'h6) ? 8'h75 : 8'h00, derate_add_ps[11:4]);
      rd(`LPMR_ADDR_TEMP, {flag, 4'h0, rate_m});
      rd(`LPMR_ADDR_TEMP, {1'b0, 4'h0, rate_m});
      idle(1);
    end
    // sensor change lands on the same edge as a clearing read
    sensor_rate <= 3'h5;
    rd(`LPMR_ADDR_TEMP, 8'h07);
    rd(`LPMR_ADDR_TEMP, 8'h85);
    rd(`LPMR_ADDR_TEMP, 8'h05);
    idle(1);
    close_out();
  end
endmodule : lpmr_mode_regs_test
`default_nettype wire
